// ==== nvc_core_model.sv ====
// stand-in for the peripherals and the core's routine entry and return sequencing
module nvc_core_model (
  input wire logic clk_i,
  output nvc_pkg::nvc_vec_t line_o,
  output nvc_pkg::nvc_evt_s entry_o,
  output nvc_pkg::nvc_evt_s return_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import nvc_pkg::*;
  // ----------------------------------------
  // quiet lines and no events at start
  // ----------------------------------------
  initial begin
    line_o = '0;
    entry_o = '0;
    return_o = '0;
  end
  // level source drives its line to the given value and holds it until the next level call
  task automatic level(input nvc_num_t n, input logic v);
    @(posedge clk_i);
    line_o[n] <= v;
  endtask
  // pulse source: high for exactly one clock
  task automatic pulse(input nvc_num_t n);
    @(posedge clk_i);
    line_o[n] <= 1'b1;
    @(posedge clk_i);
    line_o[n] <= 1'b0;
  endtask
  // one-cycle entry event; number turned over once valid drops
  task automatic enter(input nvc_num_t n);
    @(posedge clk_i);
    entry_o <= '{valid: 1'b1, num: n};
    @(posedge clk_i);
    entry_o <= '{valid: 1'b0, num: ~n};
  endtask
  // one-cycle return event
  task automatic leave(input nvc_num_t n);
    @(posedge clk_i);
    return_o <= '{valid: 1'b1, num: n};
    @(posedge clk_i);
    return_o <= '{valid: 1'b0, num: ~n};
  endtask
endmodule

// ==== nvc_map.svh ====
// register offsets, field positions and reset values of the interrupt pending state block
`ifndef NVC_MAP_SVH
`define NVC_MAP_SVH
`define NVC_NUM_IRQ 29
`define NVC_NUM_W 5
`define NVC_PRIO_W 3
`define NVC_PRIO_FIELD 4
`define NVC_PRIO_PER_WORD 8
`define NVC_OFS_CFG 8'h00
`define NVC_OFS_SETPEND 8'h04
`define NVC_OFS_CLRPEND 8'h08
`define NVC_OFS_ACTIVE 8'h0C
`define NVC_OFS_SOFTWARE_TRIGGER_REGISTER 8'h10
`define NVC_OFS_PRIO0 8'h14
`define NVC_OFS_PRIO3 8'h20
`define NVC_OFS_STAT 8'h24
`define NVC_OFS_MASK 8'h28
`define NVC_EV_W 3
`define NVC_EV_HWPEND 0
`define NVC_EV_ENTRY 1
`define NVC_EV_RETURN 2
`define NVC_RST_VEC 29'h00000000
`define NVC_RST_EV 3'h0
`define NVC_RST_WORD 32'h00000000
`endif

// ==== nvc_pending_ctrl.sv ====
// per-interrupt pending and active state logic with wishbone registers
//
// Behaviour
// - each of 29 inputs has priority 0-7
// - pulse inputs sampled each clock, latched
// - entry clears pending, sets active
// - level return: line high pends, else inactive
// - level line high while not active pends
// - rising edge on line pends
// - set-pending or trigger write pends
// - pulse during routine gives active-and-pending
// - no pulse during routine: inactive on return
// - level clear: unchanged if line high
// - pulse clear drops pending, keeps active
`include "nvc_map.svh"
module nvc_pending_ctrl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire nvc_pkg::nvc_vec_t irq_line_i,
  input wire nvc_pkg::nvc_evt_s entry_i,
  input wire nvc_pkg::nvc_evt_s return_i,
  output nvc_pkg::nvc_req_s req_o,
  output nvc_pkg::nvc_vec_t pend_o,
  output nvc_pkg::nvc_vec_t active_o,
  output logic irq_o
);
  import nvc_pkg::*;

  // ----------------------------------------------------------------
  // state and bus decode
  // ----------------------------------------------------------------
  nvc_state_s state_reg; // registered state
  nvc_state_s state_next; // next state
  logic wb_go; // new access this cycle
  logic wb_wr; // new write this cycle
  logic [31:0] wmask; // byte lane mask
  logic [31:0] wdat; // write data gated by lanes
  nvc_vec_t set_w; // software set-pending bits
  nvc_vec_t clr_w; // software clear-pending bits
  nvc_vec_t trig_w; // software trigger one-hot
  nvc_vec_t hit_entry; // entry for this number
  nvc_vec_t hit_ret; // return for this number
  nvc_vec_t rise; // low-to-high seen on line
  nvc_vec_t pend_n; // per-bit next pending
  nvc_vec_t act_n; // per-bit next active

  // one access per request; ack drops in the cycle after it was given
  // a write takes effect at the edge that takes the access, and ack rises at that same edge
  assign wb_go = wb_cyc_i && wb_stb_i && !state_reg.ack;
  assign wb_wr = wb_go && wb_we_i;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wdat = wb_dat_i & wmask;
  // software pend and clear requests
  assign set_w = (wb_wr && wb_adr_i == `NVC_OFS_SETPEND) ? wdat[`NVC_NUM_IRQ-1:0] : '0;
  assign clr_w = (wb_wr && wb_adr_i == `NVC_OFS_CLRPEND) ? wdat[`NVC_NUM_IRQ-1:0] : '0;

  // ----------------------------------------------------------------
  // per-interrupt state
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `NVC_NUM_IRQ; gi++) begin : g_irq
      // event decode for this interrupt
      // trigger numbers 29 to 31 match no interrupt, so they are dropped
      assign trig_w[gi] = wb_wr && wb_sel_i[0] && wb_adr_i == `NVC_OFS_SOFTWARE_TRIGGER_REGISTER &&
                          wb_dat_i[`NVC_NUM_W-1:0] == nvc_num_t'(gi);
      assign hit_entry[gi] = entry_i.valid && entry_i.num == nvc_num_t'(gi);
      assign hit_ret[gi] = return_i.valid && return_i.num == nvc_num_t'(gi);
      // line sampled on every clock edge, edge from last sample
      assign rise[gi] = irq_line_i[gi] && !state_reg.prev[gi];

      // active: set on entry, cleared on return
      // entry wins over a same-cycle return, so the routine stays active
      assign act_n[gi] = hit_entry[gi] || (state_reg.act[gi] && !hit_ret[gi]);

      // pending: clears first, then every detection overrides them
      // pulse mode ignores a held line; only edges and software pend it
      always_comb begin
        pend_n[gi] = state_reg.pend[gi];
        if (hit_entry[gi]) begin
          pend_n[gi] = 1'b0;
        end
        if (clr_w[gi]) begin
          if (state_reg.pulse[gi]) begin
            pend_n[gi] = 1'b0;
          end else if (!irq_line_i[gi]) begin
            pend_n[gi] = 1'b0;
          end
        end
        if (!state_reg.pulse[gi] && irq_line_i[gi] && !act_n[gi]) begin
          pend_n[gi] = 1'b1;
        end
        if (rise[gi] || set_w[gi] || trig_w[gi]) begin
          pend_n[gi] = 1'b1;
        end
      end

      // checks on each interrupt
      a_entry_sets_active: assert property (@(posedge clk_i) disable iff (rst_i)
        hit_entry[gi] |=> state_reg.act[gi] && (!state_reg.pend[gi] || $past(rise[gi]) ||
        $past(set_w[gi]) || $past(trig_w[gi])))
        else $error("entry did not move interrupt to active");
      a_rise_pends: assert property (@(posedge clk_i) disable iff (rst_i)
        rise[gi] |=> state_reg.pend[gi])
        else $error("rising edge not latched as pending");
      a_level_high_pends: assert property (@(posedge clk_i) disable iff (rst_i)
        !state_reg.pulse[gi] && irq_line_i[gi] && !state_reg.act[gi] && !hit_entry[gi]
        |=> state_reg.pend[gi])
        else $error("high level line not pending");
      a_level_return: assert property (@(posedge clk_i) disable iff (rst_i)
        hit_ret[gi] && !hit_entry[gi] && !state_reg.pulse[gi] && irq_line_i[gi]
        |=> state_reg.pend[gi] && !state_reg.act[gi])
        else $error("level return with line high did not pend");
      a_pulse_quiet_ret: assert property (@(posedge clk_i) disable iff (rst_i)
        hit_ret[gi] && !hit_entry[gi] && state_reg.pulse[gi] && !state_reg.pend[gi] &&
        !rise[gi] && !set_w[gi] && !trig_w[gi]
        |=> !state_reg.pend[gi] && !state_reg.act[gi])
        else $error("quiet pulse return not inactive");
      a_pulse_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        clr_w[gi] && state_reg.pulse[gi] && !rise[gi] && !set_w[gi] && !trig_w[gi] &&
        !hit_entry[gi] && !hit_ret[gi]
        |=> !state_reg.pend[gi] && state_reg.act[gi] == $past(state_reg.act[gi]))
        else $error("pulse clear did not drop pending only");
      a_level_clear_held: assert property (@(posedge clk_i) disable iff (rst_i)
        clr_w[gi] && !state_reg.pulse[gi] && irq_line_i[gi] && state_reg.pend[gi] &&
        !hit_entry[gi] |=> state_reg.pend[gi])
        else $error("level clear dropped pending while line high");
      a_sw_trigger: assert property (@(posedge clk_i) disable iff (rst_i)
        trig_w[gi] || set_w[gi] |=> state_reg.pend[gi] ##1 wb_ack_o == 1'b0)
        else $error("software pend write did not pend");

      // a return always ends the routine unless a new entry lands with it
      a_return_clears: assert property (@(posedge clk_i) disable iff (rst_i)
        hit_ret[gi] && !hit_entry[gi] |=> !state_reg.act[gi])
        else $error("return left interrupt active");
      // a pulse while the routine runs leaves it active and pending
      a_pulse_busy_pend: assert property (@(posedge clk_i) disable iff (rst_i)
        state_reg.pulse[gi] && state_reg.act[gi] && rise[gi] && !hit_ret[gi]
        |=> state_reg.pend[gi] && state_reg.act[gi])
        else $error("pulse during routine not active and pending");
      // the chosen request names a waiting interrupt and its own level
      a_req_named: assert property (@(posedge clk_i) disable iff (rst_i)
        state_next.req.valid && state_next.req.num == nvc_num_t'(gi)
        |-> state_reg.pend[gi] && !state_reg.act[gi] &&
        state_next.req.prio == state_reg.prio[gi])
        else $error("chosen request not a waiting interrupt");
      // nothing waiting beats the offer: more urgent, or as urgent and lower number
      a_req_most_urgent: assert property (@(posedge clk_i) disable iff (rst_i)
        state_reg.pend[gi] && !state_reg.act[gi] |=> req_o.valid &&
        (req_o.prio < $past(state_reg.prio[gi]) ||
        (req_o.prio == $past(state_reg.prio[gi]) && req_o.num <= nvc_num_t'(gi))))
        else $error("offered request outranked by a waiting interrupt");
    end
  endgenerate

  // ----------------------------------------------------------------
  // next state: bus, priorities, arbitration, status
  // ----------------------------------------------------------------
  always_comb begin
    logic [2:0] pw; // priority word index
    logic [`NVC_EV_W-1:0] ev; // events this cycle
    nvc_req_s best; // best candidate so far
    nvc_vec_t cand; // pending and not active
    state_next = state_reg;
    pw = 3'h0;
    ev = `NVC_RST_EV;
    best = '0;
    cand = state_reg.pend & ~state_reg.act;
    state_next.prev = irq_line_i;
    state_next.pend = pend_n;
    state_next.act = act_n;
    state_next.ack = wb_go;
    // register writes and reads
    if (wb_go) begin
      state_next.dat = `NVC_RST_WORD;
      if (wb_adr_i >= `NVC_OFS_PRIO0 && wb_adr_i <= `NVC_OFS_PRIO3) begin
        pw = 3'((wb_adr_i - `NVC_OFS_PRIO0) >> 2);
      end
      case (wb_adr_i)
        `NVC_OFS_CFG: begin
          state_next.dat = {3'h0, state_reg.pulse};
          if (wb_we_i) begin
            state_next.pulse = (state_reg.pulse & ~wmask[`NVC_NUM_IRQ-1:0]) |
                               wdat[`NVC_NUM_IRQ-1:0];
          end
        end
        `NVC_OFS_SETPEND, `NVC_OFS_CLRPEND: begin
          state_next.dat = {3'h0, state_reg.pend};
        end
        `NVC_OFS_ACTIVE: begin
          state_next.dat = {3'h0, state_reg.act};
        end
        `NVC_OFS_STAT: begin
          state_next.dat = {29'h0, state_reg.stat};
        end
        `NVC_OFS_MASK: begin
          state_next.dat = {29'h0, state_reg.mask};
          if (wb_we_i && wb_sel_i[0]) begin
            state_next.mask = wb_dat_i[`NVC_EV_W-1:0];
          end
        end
        default: begin
          state_next.dat = `NVC_RST_WORD;
        end
      endcase
      // priority words: 3-bit field in each nibble
      if (wb_adr_i >= `NVC_OFS_PRIO0 && wb_adr_i <= `NVC_OFS_PRIO3) begin
        for (int j = 0; j < `NVC_PRIO_PER_WORD; j++) begin
          if (int'(pw) * `NVC_PRIO_PER_WORD + j < `NVC_NUM_IRQ) begin
            state_next.dat[j*`NVC_PRIO_FIELD +: `NVC_PRIO_W] =
              state_reg.prio[int'(pw) * `NVC_PRIO_PER_WORD + j];
            if (wb_we_i && wb_sel_i[j/2]) begin
              state_next.prio[int'(pw) * `NVC_PRIO_PER_WORD + j] =
                wb_dat_i[j*`NVC_PRIO_FIELD +: `NVC_PRIO_W];
            end
          end
        end
      end
    end
    // most urgent candidate; descending scan with <= favours low numbers
    // scan runs over registered state, so the offer lags pending by a cycle
    for (int k = `NVC_NUM_IRQ - 1; k >= 0; k--) begin
      if (cand[k] && (!best.valid || state_reg.prio[k] <= best.prio)) begin
        best.valid = 1'b1;
        best.num = 5'(k);
        best.prio = state_reg.prio[k];
      end
    end
    state_next.req = best;
    // sticky events, set wins over a write-one clear
    ev[`NVC_EV_HWPEND] = |(pend_n & ~state_reg.pend & ~set_w & ~trig_w);
    ev[`NVC_EV_ENTRY] = entry_i.valid;
    ev[`NVC_EV_RETURN] = return_i.valid;
    if (wb_wr && wb_adr_i == `NVC_OFS_STAT && wb_sel_i[0]) begin
      state_next.stat = state_reg.stat & ~wb_dat_i[`NVC_EV_W-1:0];
    end
    state_next.stat = state_next.stat | ev;
    state_next.irq = |(state_reg.stat & state_reg.mask);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // synchronous reset clears state, configuration and outputs together
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs straight from the state register
  // ack stands for one cycle only; read data holds until the next access
  assign wb_dat_o = state_reg.dat;
  assign wb_ack_o = state_reg.ack;
  assign req_o = state_reg.req;
  assign pend_o = state_reg.pend;
  assign active_o = state_reg.act;
  assign irq_o = state_reg.irq;


  // ----------------------------------------------------------------
  // checks on the offer, the bus and the status
  // ----------------------------------------------------------------
  // nothing waiting means nothing offered one cycle later
  a_req_consistent: assert property (@(posedge clk_i) disable iff (rst_i)
    !(|(state_reg.pend & ~state_reg.act)) |=> !req_o.valid)
    else $error("request offered with nothing waiting");
  // every new access is answered in the next cycle
  a_ack_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("access not answered in the next cycle");
  // ack stands for exactly one cycle, even while the request is held
  a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack stood for more than one cycle");
  // the interrupt line follows the unmasked status one cycle behind
  a_irq_on: assert property (@(posedge clk_i) disable iff (rst_i)
    (|(state_reg.stat & state_reg.mask)) |=> irq_o)
    else $error("unmasked status did not raise the interrupt line");
  a_irq_off: assert property (@(posedge clk_i) disable iff (rst_i)
    !(|(state_reg.stat & state_reg.mask)) |=> !irq_o)
    else $error("interrupt line high with no unmasked status");
  // core events always land in the status, even against a clear
  a_stat_entry: assert property (@(posedge clk_i) disable iff (rst_i)
    entry_i.valid |=> state_reg.stat[`NVC_EV_ENTRY])
    else $error("entry event not recorded in status");
  a_stat_return: assert property (@(posedge clk_i) disable iff (rst_i)
    return_i.valid |=> state_reg.stat[`NVC_EV_RETURN])
    else $error("return event not recorded in status");
endmodule

// ==== nvc_pending_ctrl_tb_top.sv ====
// self-checking bench for the interrupt pending state block
`include "nvc_map.svh"
module nvc_pending_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import nvc_pkg::*;
  logic clk_i, rst_i, cyc, stb, we, wb_ack_o, irq_o;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [3:0] lane = 4'hF; // byte lanes of the next access
  logic [31:0] wdat, wb_dat_o;
  nvc_vec_t line, pend_o, active_o;
  nvc_evt_s ent, ret;
  nvc_req_s req_o;
  int err_count = 0;
  int num_checks = 0;
  int cycles = 0;
  nvc_pending_ctrl nvc_pending_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_line_i(line), .entry_i(ent),
    .return_i(ret), .req_o(req_o), .pend_o(pend_o), .active_o(active_o), .irq_o(irq_o));
  nvc_core_model nvc_core_model_inst (.clk_i(clk_i), .line_o(line), .entry_o(ent),
    .return_o(ret));
  // ----------------------------------------
  // clock, timeout and shared helpers
  // ----------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      err_count++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // let two edges land, then look off the edge
  task automatic nap();
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  // classic single cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= lane;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 16);
    q = wb_dat_o;
    chk(32'(wb_ack_o), 32'h1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // state of one interrupt as {pending, active}
  task automatic sc(input int n, input logic [31:0] e);
    nap();
    chk(32'({pend_o[n], active_o[n]}), e);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_level();
    logic [31:0] q;
    nvc_core_model_inst.level(5'h03, 1'b1);
    sc(3, 32'h2);
    nvc_core_model_inst.enter(5'h03);
    sc(3, 32'h1);
    nvc_core_model_inst.leave(5'h03);
    sc(3, 32'h2);
    wb(1'b1, `NVC_OFS_CLRPEND, 32'h00000008, q);
    sc(3, 32'h2);
    nvc_core_model_inst.level(5'h03, 1'b0);
    wb(1'b1, `NVC_OFS_CLRPEND, 32'h00000008, q);
    sc(3, 32'h0);
    $display("level test done");
  endtask
  task automatic t_pulse();
    logic [31:0] q;
    wb(1'b1, `NVC_OFS_CFG, 32'h00000080, q);
    nvc_core_model_inst.pulse(5'h07);
    sc(7, 32'h2);
    nvc_core_model_inst.enter(5'h07);
    nvc_core_model_inst.pulse(5'h07);
    sc(7, 32'h3);
    wb(1'b1, `NVC_OFS_CLRPEND, 32'h00000080, q);
    sc(7, 32'h1);
    nvc_core_model_inst.pulse(5'h07);
    nvc_core_model_inst.leave(5'h07);
    sc(7, 32'h2);
    nvc_core_model_inst.enter(5'h07);
    nvc_core_model_inst.leave(5'h07);
    sc(7, 32'h0);
    $display("pulse test done");
  endtask
  task automatic t_soft();
    logic [31:0] q;
    wb(1'b1, `NVC_OFS_SETPEND, 32'h00100000, q);
    wb(1'b1, `NVC_OFS_SOFTWARE_TRIGGER_REGISTER, 32'h00000015, q);
    wb(1'b1, `NVC_OFS_SOFTWARE_TRIGGER_REGISTER, 32'h0000001D, q);
    wb(1'b0, `NVC_OFS_SETPEND, 32'h0, q);
    chk(q, 32'h00300000);
    wb(1'b1, `NVC_OFS_CLRPEND, 32'h1FFFFFFF, q);
    nap();
    chk(32'(pend_o), 32'h0);
    $display("software test done");
  endtask
  task automatic t_prio();
    logic [31:0] q;
    wb(1'b1, `NVC_OFS_PRIO0, 32'h00000500, q);
    wb(1'b1, 8'h18, 32'h00010050, q);
    wb(1'b0, 8'h18, 32'h0, q);
    chk(q, 32'h00010050);
    wb(1'b1, `NVC_OFS_SETPEND, 32'h00001204, q);
    nap();
    chk(32'(req_o), {23'h0, 1'b1, 5'h0C, 3'h1});
    wb(1'b1, `NVC_OFS_CLRPEND, 32'h00001000, q);
    nap();
    chk(32'(req_o), {23'h0, 1'b1, 5'h02, 3'h5});
    nvc_core_model_inst.enter(5'h02);
    nap();
    chk(32'(req_o), {23'h0, 1'b1, 5'h09, 3'h5});
    wb(1'b0, `NVC_OFS_ACTIVE, 32'h0, q);
    chk(q, 32'h00000004);
    nvc_core_model_inst.leave(5'h02);
    wb(1'b1, `NVC_OFS_CLRPEND, 32'h00000200, q);
    nap();
    chk(32'(req_o.valid), 32'h0);
    $display("priority test done");
  endtask
  task automatic t_irq();
    logic [31:0] q;
    wb(1'b1, `NVC_OFS_MASK, 32'h1, q);
    nap();
    chk(32'(irq_o), 32'h1);
    wb(1'b1, `NVC_OFS_MASK, 32'h0, q);
    nap();
    chk(32'(irq_o), 32'h0);
    wb(1'b1, `NVC_OFS_STAT, 32'h7, q);
    wb(1'b0, `NVC_OFS_STAT, 32'h0, q);
    chk(q, 32'h0);
    wb(1'b1, `NVC_OFS_MASK, 32'h2, q);
    nvc_core_model_inst.enter(5'h04);
    nap();
    chk(32'(irq_o), 32'h1);
    wb(1'b1, `NVC_OFS_STAT, 32'h2, q);
    nap();
    chk(32'(irq_o), 32'h0);
    wb(1'b0, 8'h3C, 32'h0, q);
    chk(q, 32'h0);
    $display("interrupt test done");
  endtask
  // partial byte lanes, top interrupt line
  task automatic t_lanes();
    logic [31:0] q;
    lane = 4'h2;
    wb(1'b1, 8'h1C, 32'h77777777, q);
    lane = 4'h4;
    wb(1'b1, `NVC_OFS_SETPEND, 32'hFFFFFFFF, q);
    lane = 4'hE;
    wb(1'b1, `NVC_OFS_SOFTWARE_TRIGGER_REGISTER, 32'h00000005, q);
    wb(1'b1, `NVC_OFS_MASK, 32'h00000007, q);
    lane = 4'hF;
    wb(1'b0, 8'h1C, 32'h0, q);
    chk(q, 32'h00007700);
    wb(1'b0, `NVC_OFS_SETPEND, 32'h0, q);
    chk(q, 32'h00FF0000);
    wb(1'b0, `NVC_OFS_MASK, 32'h0, q);
    chk(q, 32'h2);
    nvc_core_model_inst.level(5'h1C, 1'b1);
    sc(28, 32'h2);
    nvc_core_model_inst.level(5'h1C, 1'b0);
    wb(1'b1, `NVC_OFS_CLRPEND, 32'h1FFFFFFF, q);
    nap();
    chk(32'(pend_o), 32'h0);
    $display("byte lane test done");
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    nap();
    chk(32'(pend_o | active_o), 32'h0);
    chk(32'({req_o, irq_o}), 32'h0);
    t_level();
    t_pulse();
    t_soft();
    t_prio();
    t_irq();
    t_lanes();
    summarize();
  end
endmodule

// ==== nvc_pkg.sv ====
// types shared by the interrupt pending state block
`include "nvc_map.svh"
package nvc_pkg;
  typedef logic [`NVC_NUM_IRQ-1:0] nvc_vec_t; // one bit per interrupt
  typedef logic [`NVC_PRIO_W-1:0] nvc_prio_t; // 0 is the most urgent
  typedef logic [`NVC_NUM_W-1:0] nvc_num_t; // interrupt number

  // one core event: service routine entry or return
  typedef struct packed {
    logic valid;
    nvc_num_t num;
  } nvc_evt_s;

  // request offered to the core
  typedef struct packed {
    logic valid;
    nvc_num_t num;
    nvc_prio_t prio;
  } nvc_req_s;

  // whole state of the block
  typedef struct packed {
    nvc_vec_t pulse; // 1 = pulse mode, 0 = level
    nvc_vec_t pend;
    nvc_vec_t act;
    nvc_vec_t prev; // line value of last cycle
    nvc_prio_t [`NVC_NUM_IRQ-1:0] prio;
    logic [`NVC_EV_W-1:0] stat;
    logic [`NVC_EV_W-1:0] mask;
    logic ack;
    logic [31:0] dat;
    logic irq;
    nvc_req_s req;
  } nvc_state_s;
endpackage
